// File: bench/tb.sv
`timescale 1ns/100ps
`include "video_timing_flags_defines.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t: compare", $time); end end
module tb;
  logic sys_clk = 1'h0, nrst = 1'h0, wr_en = 1'h0, rd_en = 1'h0, fld = 1'h0, vbl = 1'h0, bad = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h00000000;
  wire [31:0] rd_data;
  wire [9:0] word_in, data_out;
  wire [4:0] pos;
  wire word_en, data_out_en, line_blank, frame_blank, odd_even_field, receiver_lock_out, input_two_carrier_sense;
  int err_count = 0;
  int n_tests = 0;
  // ==========================================
  // short loss count keeps lock decisions quick
  video_timing_flags #(.LOSS_WORDS(16)) i_video_timing_flags (.sys_clk(sys_clk), .nrst(nrst), .word_in(word_in),
    .word_en(word_en), .input_two_carrier_sense(input_two_carrier_sense), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .data_out(data_out), .data_out_en(data_out_en),
    .line_blank(line_blank), .frame_blank(frame_blank), .odd_even_field(odd_even_field),
    .receiver_lock_out(receiver_lock_out));
  video_source i_video_source (.sys_clk(sys_clk), .nrst(nrst), .fld(fld), .vbl(vbl), .bad(bad), .word_in(word_in),
    .word_en(word_en), .input_two_carrier_sense(input_two_carrier_sense), .pos(pos));
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  task report_and_stop;
  begin
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // ==========================================
  // bus and wait helpers
  task rd(input logic [7:0] a, input logic [31:0] e);
  begin
    @(posedge sys_clk);
    rd_en <= 1'h1;
    addr <= a;
    @(posedge sys_clk);
    rd_en <= 1'h0;
    @(negedge sys_clk);
    `CHK(rd_data, e)
  end
  endtask
  task wr(input logic [31:0] d);
  begin
    @(posedge sys_clk);
    wr_en <= 1'h1;
    addr <= `OFS_PROCESSING_DISABLE;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en <= 1'h0;
  end
  endtask
  task at_pos(input logic [4:0] p);
    int i;
  begin
    i = 0;
    do
    begin
      @(negedge sys_clk);
      i++;
    end
    while (pos !== p && i < 60);
    if (i >= 60)
    begin
      err_count++;
      $display("wrong value at %0t: no line", $time);
      report_and_stop;
    end
  end
  endtask
  // ==========================================
  // scenarios
  task t_hmode(input logic s, input logic e);
  begin
    wr({31'h0, s});
    rd(`OFS_PROCESSING_DISABLE, {31'h0, s});
    at_pos(5'h08);
    at_pos(5'h08);
    `CHK(line_blank, 1'h1)
    at_pos(5'h12);
    `CHK(line_blank, e)
    at_pos(5'h13);
    `CHK(line_blank, e)
    at_pos(5'h14);
    `CHK(line_blank, 1'h0)
    `CHK(data_out, 10'h200)
    at_pos(5'h16);
    `CHK(line_blank, 1'h0)
  end
  endtask
  task t_fields;
    int i;
  begin
    for (i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      fld <= i[1];
      vbl <= i[0];
      at_pos(5'h16);
      at_pos(5'h16);
      `CHK(frame_blank, i[0])
      `CHK(odd_even_field, i[1])
      `CHK(receiver_lock_out, 1'h1)
      rd(`OFS_TIMING_STATUS, {27'h0, i[1], i[0], 3'h3});
    end
  end
  endtask
  task t_carrier;
  begin
    @(posedge sys_clk);
    bad <= 1'h1;
    repeat (5) @(posedge sys_clk);
    rd(`OFS_TIMING_STATUS, 32'h00000000);
    `CHK(data_out_en | line_blank | frame_blank | odd_even_field | receiver_lock_out | (|data_out), 1'h0)
    @(posedge sys_clk);
    bad <= 1'h0;
    at_pos(5'h16);
    at_pos(5'h16);
    `CHK(receiver_lock_out & data_out_en & frame_blank, 1'h1)
  end
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'h1;
    rd(`OFS_PROCESSING_DISABLE, 32'h00000000);
    rd(8'h08, 32'h00000000);
    t_hmode(1'h0, 1'h1);
    t_hmode(1'h1, 1'h0);
    t_fields;
    t_carrier;
    report_and_stop;
  end
endmodule // tb

// File: bench/video_source.sv
`timescale 1ns/100ps
module video_source (
  input wire sys_clk,
  input wire nrst,
  input wire fld,
  input wire vbl,
  input wire bad,
  output logic [9:0] word_in,
  output logic word_en,
  output logic input_two_carrier_sense,
  output logic [4:0] pos
);
  // ==========================================
  // 24-word line: eav, blanking, sav, active
  wire [4:0] p = (pos < 5'h0c) ? pos : pos - 5'h0c;
  wire sav = pos >= 5'h0c;
  initial
  begin
    pos = 5'h00;
    word_en = 1'h0;
    input_two_carrier_sense = 1'h0;
  end
  always @(posedge sys_clk)
  begin
    word_en <= nrst;
    pos <= (nrst && pos != 5'h17) ? pos + 5'h01 : 5'h00;
    input_two_carrier_sense <= bad;
  end
  // protection bits left zero, the receiver ignores them
  assign word_in = (p == 5'h00) ? 10'h3ff : (p < 5'h03) ? 10'h000 :
    (p == 5'h03) ? {1'h1, fld, vbl, !sav, 6'h00} : sav ? 10'h200 : 10'h040;
endmodule // video_source

// File: bench/video_timing_flags_monitor.sv
`timescale 1ns/100ps
module video_timing_flags_monitor (
  input wire sys_clk,
  input wire nrst,
  input wire [9:0] word_in,
  input wire word_en,
  input wire input_two_carrier_sense,
  input wire [7:0] addr,
  input wire [31:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [31:0] rd_data,
  input wire [9:0] data_out,
  input wire data_out_en,
  input wire line_blank,
  input wire frame_blank,
  input wire odd_even_field,
  input wire receiver_lock_out
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // ==========================================
  // carrier handling
  mute_out_a:
    assert property (input_two_carrier_sense [*3] |=> !receiver_lock_out && !data_out_en && !line_blank
      && !frame_blank && !odd_even_field && data_out == 10'h000) else $error("outputs not muted");
  lock_hold_a:
    assert property ($rose(input_two_carrier_sense) && receiver_lock_out |=> receiver_lock_out)
      else $error("carrier acted on unsynchronised");
  // pin to output takes two synchroniser flops plus the output flop
  lock_valid_a:
    assert property (receiver_lock_out || data_out_en |-> !$past(input_two_carrier_sense, 3))
      else $error("active without valid carrier");
  // ==========================================
  // frame and field flags move, and the line flag rises, only on a reference word
  vflag_trs_a:
    assert property (data_out_en && $past(data_out_en) && $changed(frame_blank) |-> data_out == 10'h3ff)
      else $error("frame flag moved off reference");
  fflag_trs_a:
    assert property (data_out_en && $past(data_out_en) && $changed(odd_even_field) |-> data_out == 10'h3ff)
      else $error("field flag moved off reference");
  hflag_trs_a:
    assert property ($rose(line_blank) && $past(data_out_en) |-> data_out == 10'h3ff)
      else $error("line flag rose off reference");
  out_strobe_a:
    assert property (data_out_en |-> $past(word_en)) else $error("output strobe without word");
  rd_idle_a:
    assert property (!$past(rd_en) |-> rd_data == 32'h00000000) else $error("read data outside slot");
endmodule // video_timing_flags_monitor
bind video_timing_flags video_timing_flags_monitor i_video_timing_flags_monitor (.sys_clk(sys_clk), .nrst(nrst),
  .word_in(word_in), .word_en(word_en), .input_two_carrier_sense(input_two_carrier_sense), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .data_out(data_out),
  .data_out_en(data_out_en), .line_blank(line_blank), .frame_blank(frame_blank),
  .odd_even_field(odd_even_field), .receiver_lock_out(receiver_lock_out));

// File: hdl/video_timing_flags.v
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "video_timing_flags_defines.vh"

module video_timing_flags #(
  parameter WORD_W = 10,
  parameter ADDR_W = 8,
  parameter DATA_W = 32,
  parameter LOSS_WORDS = `TRS_LOSS_WORDS
) (
  input wire sys_clk,
  input wire nrst,
  input wire [WORD_W-1:0] word_in,
  input wire word_en,
  input wire input_two_carrier_sense,
  input wire [ADDR_W-1:0] addr,
  input wire [DATA_W-1:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [DATA_W-1:0] rd_data,
  output reg [WORD_W-1:0] data_out,
  output reg data_out_en,
  output reg line_blank,
  output reg frame_blank,
  output reg odd_even_field,
  output reg receiver_lock_out
);

  // ==========================================================
  // address decode
  // ==========================================================
  function is_reg;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] ofs;
    begin
      is_reg = (a == ofs);
    end
  endfunction

  // ==========================================================
  // carrier sense synchroniser
  // ==========================================================
  reg carrier_meta_reg;
  reg carrier_sync_reg;

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      carrier_meta_reg <= 1'b1;
      carrier_sync_reg <= 1'b1;
    end
    else
    begin
      carrier_meta_reg <= input_two_carrier_sense;
      carrier_sync_reg <= carrier_meta_reg;
    end
  end

  // low level means a valid input
  wire carrier_ok = ~carrier_sync_reg;

  // ==========================================================
  // configuration register
  // ==========================================================
  reg line_blank_select_reg;

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      line_blank_select_reg <= `RST_LINE_BLANK_SELECT;
    end
    else if (wr_en && is_reg(addr, `OFS_PROCESSING_DISABLE))
    begin
      line_blank_select_reg <= wr_data[`BIT_LINE_BLANK_SELECT];
    end
  end

  // ==========================================================
  // word pipeline and reference detection
  // ==========================================================
  // three words of delay let the flags change together with the
  // first preamble word on the output, not with the id word
  reg [WORD_W-1:0] stage0_reg;
  reg [WORD_W-1:0] stage1_reg;
  reg [WORD_W-1:0] stage2_reg;

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      stage0_reg <= {WORD_W{1'b0}};
      stage1_reg <= {WORD_W{1'b0}};
      stage2_reg <= {WORD_W{1'b0}};
    end
    else if (word_en)
    begin
      stage0_reg <= word_in;
      stage1_reg <= stage0_reg;
      stage2_reg <= stage1_reg;
    end
  end

  wire trs_found = word_en &&
                   (stage2_reg == `TRS_PREAMBLE_ONES) &&
                   (stage1_reg == `TRS_PREAMBLE_ZEROS) &&
                   (stage0_reg == `TRS_PREAMBLE_ZEROS) &&
                   word_in[`TRS_ID_MARK];
  wire id_hblank = word_in[`TRS_ID_HBLANK];
  wire id_vblank = word_in[`TRS_ID_VBLANK];
  wire id_field = word_in[`TRS_ID_FIELD];

  // ==========================================================
  // timing flag tracking
  // ==========================================================
  reg hblank_words_reg;
  reg hblank_bit_reg;
  reg vblank_bit_reg;
  reg field_bit_reg;
  reg [2:0] sav_tail_reg;

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      hblank_words_reg <= 1'b0;
      hblank_bit_reg <= 1'b0;
      vblank_bit_reg <= 1'b0;
      field_bit_reg <= 1'b0;
      sav_tail_reg <= 3'h0;
    end
    else if (trs_found)
    begin
      // flag taken from the H bit only
      hblank_bit_reg <= id_hblank;
      // vertical flag from the V bit
      vblank_bit_reg <= id_vblank;
      // field one, progressive keep it low
      field_bit_reg <= id_field;
      if (id_hblank)
      begin
        hblank_words_reg <= 1'b1;
        sav_tail_reg <= 3'h0;
      end
      else
      begin
        hblank_words_reg <= 1'b1;
        sav_tail_reg <= `TRS_WORDS;
      end
    end
    else if (word_en && sav_tail_reg != 3'h0)
    begin
      sav_tail_reg <= sav_tail_reg - 3'h1;
      // fall after the start-of-active id word
      if (sav_tail_reg == 3'h1)
      begin
        hblank_words_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // lock tracking
  // ==========================================================
  reg trs_seen_reg;
  reg [13:0] loss_cnt_reg;

  // lock needs a live carrier and recent reference words; a
  // stream that stops carrying them drops lock after a while
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      trs_seen_reg <= 1'b0;
      loss_cnt_reg <= 14'h0;
    end
    else if (!carrier_ok)
    begin
      trs_seen_reg <= 1'b0;
      loss_cnt_reg <= 14'h0;
    end
    else if (trs_found)
    begin
      trs_seen_reg <= 1'b1;
      loss_cnt_reg <= 14'h0;
    end
    else if (word_en && trs_seen_reg)
    begin
      if (loss_cnt_reg == LOSS_WORDS[13:0] - 14'h1)
      begin
        trs_seen_reg <= 1'b0;
        loss_cnt_reg <= 14'h0;
      end
      else
      begin
        loss_cnt_reg <= loss_cnt_reg + 14'h1;
      end
    end
  end

  // ==========================================================
  // parallel outputs
  // ==========================================================
  // drop with the first active word
  wire hblank_next = trs_found ? 1'b1 : (sav_tail_reg == 3'h1) ? 1'b0 : hblank_words_reg;
  wire hbit_next = trs_found ? id_hblank : hblank_bit_reg;
  wire vbit_next = trs_found ? id_vblank : vblank_bit_reg;
  wire fbit_next = trs_found ? id_field : field_bit_reg;

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      data_out <= {WORD_W{1'b0}};
      data_out_en <= 1'b0;
      line_blank <= 1'b0;
      frame_blank <= 1'b0;
      odd_even_field <= 1'b0;
      receiver_lock_out <= 1'b0;
    end
    else if (!carrier_ok)
    begin
      data_out <= {WORD_W{1'b0}};
      data_out_en <= 1'b0;
      line_blank <= 1'b0;
      frame_blank <= 1'b0;
      odd_even_field <= 1'b0;
      receiver_lock_out <= 1'b0;
    end
    else
    begin
      receiver_lock_out <= trs_seen_reg | trs_found;
      data_out_en <= word_en;
      if (word_en)
      begin
        data_out <= stage2_reg;
        // flag chosen by the select bit
        line_blank <= line_blank_select_reg ? hbit_next : hblank_next;
        frame_blank <= vbit_next;
        odd_even_field <= fbit_next;
      end
    end
  end

  // ==========================================================
  // register read port
  // ==========================================================
  wire [DATA_W-1:0] status_word =
    ({{(DATA_W-1){1'b0}}, receiver_lock_out} << `BIT_STAT_LOCK) |
    ({{(DATA_W-1){1'b0}}, carrier_ok} << `BIT_STAT_CARRIER_OK) |
    ({{(DATA_W-1){1'b0}}, line_blank} << `BIT_STAT_LINE_BLANK) |
    ({{(DATA_W-1){1'b0}}, frame_blank} << `BIT_STAT_FRAME_BLANK) |
    ({{(DATA_W-1){1'b0}}, odd_even_field} << `BIT_STAT_FIELD);

  wire [DATA_W-1:0] config_word =
    {{(DATA_W-1){1'b0}}, line_blank_select_reg} << `BIT_LINE_BLANK_SELECT;

  // unmapped reads return zero; data stands only for one cycle
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      rd_data <= {DATA_W{1'b0}};
    end
    else if (rd_en && is_reg(addr, `OFS_PROCESSING_DISABLE))
    begin
      rd_data <= config_word;
    end
    else if (rd_en && is_reg(addr, `OFS_TIMING_STATUS))
    begin
      rd_data <= status_word;
    end
    else
    begin
      rd_data <= {DATA_W{1'b0}};
    end
  end

endmodule // video_timing_flags

// File: hdl/video_timing_flags_defines.vh
`ifndef VIDEO_TIMING_FLAGS_DEFINES_VH
`define VIDEO_TIMING_FLAGS_DEFINES_VH

// ==========================================================
// register map (byte offsets)
// ==========================================================
`define OFS_PROCESSING_DISABLE 8'h00
`define OFS_TIMING_STATUS 8'h04

// ==========================================================
// field positions
// ==========================================================
`define BIT_LINE_BLANK_SELECT 0
`define BIT_STAT_LOCK 0
`define BIT_STAT_CARRIER_OK 1
`define BIT_STAT_LINE_BLANK 2
`define BIT_STAT_FRAME_BLANK 3
`define BIT_STAT_FIELD 4

// ==========================================================
// reset values
// ==========================================================
`define RST_LINE_BLANK_SELECT 1'b0

// ==========================================================
// timing reference word layout
// ==========================================================
`define TRS_PREAMBLE_ONES 10'h3ff
`define TRS_PREAMBLE_ZEROS 10'h000
`define TRS_ID_MARK 9
`define TRS_ID_FIELD 8
`define TRS_ID_VBLANK 7
`define TRS_ID_HBLANK 6

// ==========================================================
// timing counts
// ==========================================================
`define TRS_WORDS 3'h4
`define TRS_LOSS_WORDS 8192

`endif
